/* File: hdl/pdc_config_regs.sv */
// Pin and device configuration registers with the pin behaviour they steer
//
// Function
// - The DC bus voltage filter runs while the filter-disable bit is 0 and is bypassed at 1.
// - With the motor stopped the tach pin passes pulses for code 0, goes high for 1 or 3, low for 2.
// - In a fault the tach pin holds the last driving level for 0, goes high for 1, low for 2.
// - The alarm pin is driven only while the alarm enable bit is 1.
// - Braking follows the stop request pin for codes 0 and 3, is forced for 1, never for 2.
// - The speed reference comes from the pin amplitude for source 0 and its duty for source 1.
// - The speed reference comes from the digital speed command for 2 and the pin frequency for 3.
// - The monitor DAC output is enabled only while its enable bit is 1.
// - The serial pin drive strength code goes straight to the pad drivers.
// - The internal pull-ups on the fault and tach pins follow the pull-up enable bit.
// - The bus voltage range is 15, 30 or 60 V for codes 0 to 2; code 3 is reserved.
// - The pin register sits at offset a4 and clears to zero at reset.
// - In frequency mode the duty is the measured frequency over the full-scale frequency.
`timescale 1ns/10ps
module pdc_config_regs
  import pdc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Serial register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // DC bus voltage samples
  input wire logic [11:0] vdc_raw,
  output logic [11:0] vdc_out,
  // Tach output
  input wire logic motor_stopped,
  input wire logic fault_active,
  input wire logic tach_pulse,
  output logic tach_output,
  // Alarm
  input wire logic alarm_event,
  output logic alarm_out,
  output logic alarm_oe,
  // Brake
  input wire logic stop_request_pin,
  output logic brake_apply,
  // Speed reference
  input wire logic [15:0] rate_amplitude,
  input wire logic [15:0] rate_duty,
  input wire logic [14:0] rate_frequency,
  input wire logic [14:0] full_scale_input_frequency,
  input wire logic [15:0] digital_speed_command,
  output logic [15:0] speed_ref,
  // Pad and analog configuration
  output logic monitor_dac_enable,
  output logic [6:0] serial_target_address,
  output logic [1:0] serial_pin_drive_strength,
  output logic internal_pullup_enable,
  output logic [1:0] max_dc_bus_voltage_range,
  output logic [5:0] max_dc_bus_volts
);

  logic [31:0] pin_q;
  logic [31:0] dev_q;
  logic [1:0] idle_code;
  logic [1:0] fault_code;
  logic [1:0] brake_code;
  pdc_src_t src;
  logic [14:0] filt_acc_q;
  logic last_drive_q;
  logic stop_s1_q;
  logic stop_s2_q;
  logic stop_s3_q;
  logic stop_q;
  logic [29:0] freq_num;
  logic [29:0] freq_quo;
  logic [15:0] freq_duty;

  assign idle_code = pin_q[PDC_IDLE_LSB +: 2];
  assign fault_code = pin_q[PDC_FAULT_LSB +: 2];
  assign brake_code = pin_q[PDC_BRAKE_LSB +: 2];
  assign src = pdc_src_t'(pin_q[PDC_SPEED_LSB +: 2]);

  // Register writes; reserved positions are masked off so they stay zero
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_q <= PDC_PIN_RST;
      dev_q <= PDC_DEV_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == PDC_PIN_OFS)
        pin_q <= reg_wdata & PDC_PIN_WMASK;
      if (reg_addr == PDC_DEV_OFS)
        dev_q <= reg_wdata & PDC_DEV_WMASK;
    end
  end

  // Read data is registered; unmapped offsets answer zero
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      if (reg_addr == PDC_PIN_OFS)
        reg_rdata <= pin_q & PDC_PIN_WMASK;
      else if (reg_addr == PDC_DEV_OFS)
        reg_rdata <= dev_q & PDC_DEV_WMASK;
      else
        reg_rdata <= 32'h0000_0000;
    end
  end

  // First-order low pass, gain 1/8; the accumulator holds eight times the output
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      filt_acc_q <= 15'h0000;
    else
      filt_acc_q <= filt_acc_q - (filt_acc_q >> 3) + {3'h0, vdc_raw};
  end

  // Bypass trades noise rejection for the unfiltered step response
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      vdc_out <= 12'h000;
    else if (pin_q[PDC_FILT_DIS_BIT])
      vdc_out <= vdc_raw;
    else
      vdc_out <= filt_acc_q[14:3];
  end

  // Remember the tach level last seen while driving, for fault code 0
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      last_drive_q <= 1'b0;
    else if (!motor_stopped && !fault_active)
      last_drive_q <= tach_pulse;
  end

  // Tach pin; a fault outranks the stopped state, undefined fault code 3 reads high
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      tach_output <= 1'b0;
    else if (fault_active)
    begin
      case (fault_code)
        PDC_TACH_PASS: tach_output <= last_drive_q;
        PDC_TACH_LOW: tach_output <= 1'b0;
        default: tach_output <= 1'b1;
      endcase
    end
    else if (motor_stopped)
    begin
      case (idle_code)
        PDC_TACH_PASS: tach_output <= tach_pulse;
        PDC_TACH_LOW: tach_output <= 1'b0;
        default: tach_output <= 1'b1;
      endcase
    end
    else
      tach_output <= tach_pulse;
  end

  // Alarm pin is released entirely while the function is off
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      alarm_out <= 1'b0;
      alarm_oe <= 1'b0;
    end
    else
    begin
      alarm_oe <= pin_q[PDC_ALARM_BIT];
      alarm_out <= pin_q[PDC_ALARM_BIT] & alarm_event;
    end
  end

  // Stop request pin synchroniser; the level moves only when stages two and three agree
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      stop_s1_q <= 1'b0;
      stop_s2_q <= 1'b0;
      stop_s3_q <= 1'b0;
      stop_q <= 1'b0;
    end
    else
    begin
      stop_s1_q <= stop_request_pin;
      stop_s2_q <= stop_s1_q;
      stop_s3_q <= stop_s2_q;
      if (stop_s2_q == stop_s3_q)
        stop_q <= stop_s3_q;
    end
  end

  // Brake decision
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      brake_apply <= 1'b0;
    else
    begin
      case (brake_code)
        PDC_BRAKE_FORCE: brake_apply <= 1'b1;
        PDC_BRAKE_NEVER: brake_apply <= 1'b0;
        default: brake_apply <= stop_q;
      endcase
    end
  end

  // Frequency to Q15 duty; a zero full scale gives zero rather than a divide fault
  assign freq_num = {rate_frequency, 15'h0000};
  assign freq_quo = (full_scale_input_frequency == 15'h0000) ? 30'h0000_0000 :
                    freq_num / {15'h0000, full_scale_input_frequency};
  assign freq_duty = (freq_quo > {14'h0000, PDC_REF_MAX}) ? PDC_REF_MAX : freq_quo[15:0];

  // Speed reference source select
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      speed_ref <= 16'h0000;
    else
    begin
      case (src)
        PDC_SRC_ANALOG: speed_ref <= rate_amplitude;
        PDC_SRC_DUTY: speed_ref <= rate_duty;
        PDC_SRC_DIGITAL: speed_ref <= digital_speed_command;
        PDC_SRC_FREQ: speed_ref <= freq_duty;
        default: speed_ref <= 16'h0000;
      endcase
    end
  end

  // Pad and analog controls straight from the device word
  assign monitor_dac_enable = dev_q[PDC_DAC_BIT];
  assign serial_target_address = dev_q[PDC_ADDR_LSB +: 7];
  assign serial_pin_drive_strength = dev_q[PDC_DRIVE_LSB +: 2];
  assign internal_pullup_enable = dev_q[PDC_PULLUP_BIT];
  assign max_dc_bus_voltage_range = dev_q[PDC_VOLT_LSB +: 2];

  // Reserved range code reports zero volts so misuse is visible
  always_comb
  begin
    case (dev_q[PDC_VOLT_LSB +: 2])
      2'h0: max_dc_bus_volts = PDC_VOLT_0;
      2'h1: max_dc_bus_volts = PDC_VOLT_1;
      2'h2: max_dc_bus_volts = PDC_VOLT_2;
      default: max_dc_bus_volts = 6'h00;
    endcase
  end

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  filt_bypass_a: assert property (pin_q[PDC_FILT_DIS_BIT] |=> vdc_out == $past(vdc_raw))
    else $error("filter bypass output wrong");
  filt_active_a: assert property (!pin_q[PDC_FILT_DIS_BIT] |=> vdc_out == $past(filt_acc_q[14:3]))
    else $error("filtered output wrong");
  tach_idle_a: assert property ((motor_stopped && !fault_active && idle_code == PDC_TACH_LOW)
    |=> !tach_output)
    else $error("idle tach not low");
  tach_fault_a: assert property ((fault_active && fault_code == PDC_TACH_HIGH) |=> tach_output)
    else $error("fault tach not high");
  alarm_gate_a: assert property (!pin_q[PDC_ALARM_BIT] |=> !alarm_oe && !alarm_out)
    else $error("alarm driven while disabled");
  brake_force_a: assert property (brake_code == PDC_BRAKE_FORCE |=> brake_apply)
    else $error("forced brake missing");
  brake_never_a: assert property (brake_code == PDC_BRAKE_NEVER |=> !brake_apply)
    else $error("brake applied while overridden off");
  speed_digital_a: assert property (src == PDC_SRC_DIGITAL
    |=> speed_ref == $past(digital_speed_command))
    else $error("digital speed reference wrong");
  speed_duty_a: assert property (src == PDC_SRC_DUTY |=> speed_ref == $past(rate_duty))
    else $error("duty speed reference wrong");
  dac_write_a: assert property ((reg_wr && reg_addr == PDC_DEV_OFS)
    |=> monitor_dac_enable == $past(reg_wdata[PDC_DAC_BIT]))
    else $error("dac enable not updated");
  reserved_bits_a: assert property ((pin_q & ~PDC_PIN_WMASK) == 32'h0000_0000
    && (dev_q & ~PDC_DEV_WMASK) == 32'h0000_0000)
    else $error("reserved register bits hold nonzero");

  brake_pin_c: cover property (brake_code == 2'h0 && stop_q ##1 brake_apply);
  freq_mode_c: cover property (src == PDC_SRC_FREQ && full_scale_input_frequency != 15'h0000);
  fault_hold_c: cover property (fault_active && fault_code == PDC_TACH_PASS ##1 tach_output);
  pin_write_c: cover property (reg_wr && reg_addr == PDC_PIN_OFS ##1 reg_rd && reg_addr == PDC_PIN_OFS);

endmodule

/* File: common/pdc_pkg.sv */
// Constants for the pin and device configuration register bank
package pdc_pkg;
  // Register offsets on the serial register port
  localparam logic [7:0] PDC_PIN_OFS = 8'ha4;
  localparam logic [7:0] PDC_DEV_OFS = 8'ha6;
  // Values after reset
  localparam logic [31:0] PDC_PIN_RST = 32'h0000_0000;
  localparam logic [31:0] PDC_DEV_RST = 32'h0000_0000;
  // Writable bit masks; every other position is reserved
  localparam logic [31:0] PDC_PIN_WMASK = 32'h0800_07cf;
  localparam logic [31:0] PDC_DEV_WMASK = 32'h0ff0_001f;
  // Field positions of pin_behaviour_word
  localparam int PDC_FILT_DIS_BIT = 27;
  localparam int PDC_IDLE_LSB = 9;
  localparam int PDC_FAULT_LSB = 7;
  localparam int PDC_ALARM_BIT = 6;
  localparam int PDC_BRAKE_LSB = 2;
  localparam int PDC_SPEED_LSB = 0;
  // Field positions of device_options_word
  localparam int PDC_DAC_BIT = 27;
  localparam int PDC_ADDR_LSB = 20;
  localparam int PDC_DRIVE_LSB = 3;
  localparam int PDC_PULLUP_BIT = 2;
  localparam int PDC_VOLT_LSB = 0;
  // Tach behaviour codes
  localparam logic [1:0] PDC_TACH_PASS = 2'h0;
  localparam logic [1:0] PDC_TACH_HIGH = 2'h1;
  localparam logic [1:0] PDC_TACH_LOW = 2'h2;
  // Brake override codes
  localparam logic [1:0] PDC_BRAKE_FORCE = 2'h1;
  localparam logic [1:0] PDC_BRAKE_NEVER = 2'h2;
  // Bus voltage range in volts per code
  localparam logic [5:0] PDC_VOLT_0 = 6'h0f;
  localparam logic [5:0] PDC_VOLT_1 = 6'h1e;
  localparam logic [5:0] PDC_VOLT_2 = 6'h3c;
  // Full scale of the Q15 speed reference
  localparam logic [15:0] PDC_REF_MAX = 16'h7fff;
  // Speed reference sources
  typedef enum logic [1:0] {
    PDC_SRC_ANALOG,
    PDC_SRC_DUTY,
    PDC_SRC_DIGITAL,
    PDC_SRC_FREQ
  } pdc_src_t;
endpackage

/* File: verif/pdc_config_regs_tb_top.sv */
// Self-checking testbench for the pin and device configuration registers
`timescale 1ns/10ps
`define PDC_CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pdc_config_regs_tb_top
  import pdc_pkg::*;
;
  logic clock, nrst, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [11:0] vdc_raw, vdc_out;
  logic motor_stopped, fault_active, tach_pulse, tach_output;
  logic alarm_event, alarm_out, alarm_oe, stop_request_pin, brake_apply;
  logic [15:0] rate_amplitude, rate_duty, digital_speed_command, speed_ref;
  logic [14:0] rate_frequency, full_scale_input_frequency;
  logic monitor_dac_enable, internal_pullup_enable;
  logic [6:0] serial_target_address;
  logic [1:0] serial_pin_drive_strength, max_dc_bus_voltage_range;
  logic [5:0] max_dc_bus_volts;
  logic [5:0] volt_tab [4];
  logic [15:0] ref_tab [4];
  int errors = 0;
  int checks_done = 0;

  pdc_config_regs i_pdc_config_regs (
    .clock(clock),
    .nrst(nrst),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .vdc_raw(vdc_raw),
    .vdc_out(vdc_out),
    .motor_stopped(motor_stopped),
    .fault_active(fault_active),
    .tach_pulse(tach_pulse),
    .tach_output(tach_output),
    .alarm_event(alarm_event),
    .alarm_out(alarm_out),
    .alarm_oe(alarm_oe),
    .stop_request_pin(stop_request_pin),
    .brake_apply(brake_apply),
    .rate_amplitude(rate_amplitude),
    .rate_duty(rate_duty),
    .rate_frequency(rate_frequency),
    .full_scale_input_frequency(full_scale_input_frequency),
    .digital_speed_command(digital_speed_command),
    .speed_ref(speed_ref),
    .monitor_dac_enable(monitor_dac_enable),
    .serial_target_address(serial_target_address),
    .serial_pin_drive_strength(serial_pin_drive_strength),
    .internal_pullup_enable(internal_pullup_enable),
    .max_dc_bus_voltage_range(max_dc_bus_voltage_range),
    .max_dc_bus_volts(max_dc_bus_volts)
  );

  // Free-running 50 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Prints the counts and the verdict, then stops the run
  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  // One-cycle write strobe; the spare idle cycle keeps back-to-back strobes apart
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask

  // Read data is registered, so it is sampled one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    tick(1);
    v = reg_rdata;
  endtask

  // Hang guard: far above the fewer than five hundred cycles the sequence needs
  initial
  begin
    #1000000;
    errors++;
    results();
  end

  initial
  begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, vdc_raw, motor_stopped} = '0;
    {fault_active, tach_pulse, alarm_event, stop_request_pin} = '0;
    rate_amplitude = 16'h1111;
    rate_duty = 16'h2222;
    digital_speed_command = 16'h3333;
    rate_frequency = 15'h1000;
    full_scale_input_frequency = 15'h4000;
    volt_tab = '{PDC_VOLT_0, PDC_VOLT_1, PDC_VOLT_2, 6'h00};
    ref_tab = '{16'h1111, 16'h2222, 16'h3333, 16'h2000};
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    `PDC_CHK(max_dc_bus_volts, PDC_VOLT_0)
    rd(PDC_PIN_OFS, d);
    `PDC_CHK(d, PDC_PIN_RST)
    rd(PDC_DEV_OFS, d);
    `PDC_CHK(d, PDC_DEV_RST)
    // Reserved positions must drop written ones; unmapped offsets stay inert
    wr(PDC_PIN_OFS, 32'hffff_ffff);
    wr(PDC_DEV_OFS, 32'hffff_ffff);
    wr(8'ha8, 32'h0000_0000);
    rd(PDC_PIN_OFS, d);
    `PDC_CHK(d, PDC_PIN_WMASK)
    rd(PDC_DEV_OFS, d);
    `PDC_CHK(d, PDC_DEV_WMASK)
    rd(8'ha8, d);
    `PDC_CHK(d, 32'h0000_0000)
    `PDC_CHK(serial_target_address, 7'h7f)
    // Every code of the drive, range, DAC and pull-up fields
    for (int i = 0; i < 4; i++)
    begin
      wr(PDC_DEV_OFS, (32'(i) << PDC_DRIVE_LSB) | (32'(i) << PDC_VOLT_LSB) |
         (32'(i & 1) << PDC_DAC_BIT) | (32'(i >> 1) << PDC_PULLUP_BIT));
      `PDC_CHK(serial_pin_drive_strength, 2'(i))
      `PDC_CHK(max_dc_bus_voltage_range, 2'(i))
      `PDC_CHK(max_dc_bus_volts, volt_tab[i])
      `PDC_CHK(monitor_dac_enable, 1'(i & 1))
      `PDC_CHK(internal_pullup_enable, 1'(i >> 1))
    end
    // Each speed source, then frequency clamping and a zero full scale
    for (int i = 0; i < 4; i++)
    begin
      wr(PDC_PIN_OFS, 32'(i) << PDC_SPEED_LSB);
      tick(2);
      `PDC_CHK(speed_ref, ref_tab[i])
    end
    rate_frequency = 15'h7000;
    tick(2);
    `PDC_CHK(speed_ref, PDC_REF_MAX)
    full_scale_input_frequency = 15'h0000;
    tick(2);
    `PDC_CHK(speed_ref, 16'h0000)
    // Brake codes against both pin levels, allowing for the synchroniser
    for (int i = 0; i < 8; i++)
    begin
      wr(PDC_PIN_OFS, 32'(i >> 1) << PDC_BRAKE_LSB);
      stop_request_pin = 1'(i & 1);
      tick(7);
      `PDC_CHK(brake_apply, (i >> 1) == 1 ? 1'b1 : (i >> 1) == 2 ? 1'b0 : 1'(i & 1))
    end
    for (int i = 0; i < 2; i++)
    begin
      wr(PDC_PIN_OFS, 32'(i) << PDC_ALARM_BIT);
      alarm_event = 1'b1;
      tick(2);
      `PDC_CHK({alarm_oe, alarm_out}, {1'(i), 1'(i)})
    end
    // Enabled pin stays driven but quiet without an alarm event
    alarm_event = 1'b0;
    tick(2);
    `PDC_CHK({alarm_oe, alarm_out}, 2'h2)
    // Idle codes; code 0 passes pulses in both directions
    motor_stopped = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      wr(PDC_PIN_OFS, 32'(i & 3) << PDC_IDLE_LSB);
      tach_pulse = (i == 4);
      tick(2);
      `PDC_CHK(tach_output, i == 2 ? 1'b0 : i == 0 ? 1'b0 : 1'b1)
    end
    // Fault wins over idle low; code 0 keeps the level seen while running
    motor_stopped = 1'b0;
    tach_pulse = 1'b1;
    tick(2);
    fault_active = 1'b1;
    motor_stopped = 1'b1;
    tach_pulse = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      wr(PDC_PIN_OFS, (32'(i) << PDC_FAULT_LSB) | (32'(2) << PDC_IDLE_LSB));
      tick(2);
      `PDC_CHK(tach_output, i == 2 ? 1'b0 : 1'b1)
    end
    // Filtered output lags a step, settles on it, and a bypass follows at once
    wr(PDC_PIN_OFS, 32'h0);
    vdc_raw = 12'h800;
    tick(3);
    `PDC_CHK(vdc_out < 12'h800, 1'b1)
    tick(300);
    `PDC_CHK(vdc_out, 12'h800)
    wr(PDC_PIN_OFS, 32'h1 << PDC_FILT_DIS_BIT);
    vdc_raw = 12'h123;
    tick(2);
    `PDC_CHK(vdc_out, 12'h123)
    // A second reset in mid-run clears the pin register again
    nrst = 1'b0;
    tick(1);
    nrst = 1'b1;
    rd(PDC_PIN_OFS, d);
    `PDC_CHK(d, PDC_PIN_RST)
    results();
  end
endmodule
